//--- dv/subtract_with_borrow_exec_tb_top.sv
`timescale 1ns/1ns
module subtract_with_borrow_exec_tb_top;
   logic clk, rst, instr_valid, ext_set_enable, acc_load, flags_load, mem_load;
   logic [15:0] instr_word;
   logic [3:0] bank_select_reg;
   logic [11:0] index_base, mem_load_addr, peek_addr;
   logic [7:0] acc_load_value, mem_load_data, peek_data, acc;
   logic [4:0] flags_load_value, flags;
   logic busy, done, illegal;
   int n_mismatch, n_tests;

   subtract_with_borrow_exec #(.MEM_ADDR_W(12)) dut (.clk, .rst, .instr_valid, .instr_word, .ext_set_enable,
      .bank_select_reg, .index_base, .acc_load, .acc_load_value, .flags_load, .flags_load_value, .mem_load,
      .mem_load_addr, .mem_load_data, .peek_addr, .peek_data, .acc, .flags, .busy, .done, .illegal);

   // free-running clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic report_and_stop();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   // preload accumulator, flags and one memory byte while idle
   task automatic setup(input logic [7:0] a, input logic [4:0] f, input logic [11:0] ad, input logic [7:0] d);
      acc_load = 1'b1;
      acc_load_value = a;
      flags_load = 1'b1;
      flags_load_value = f;
      mem_load = 1'b1;
      mem_load_addr = ad;
      mem_load_data = d;
      @(negedge clk);
      acc_load = 1'b0;
      flags_load = 1'b0;
      mem_load = 1'b0;
   endtask : setup

   // issue one word and time the answer; done after Q4, illegal after Q1
   task automatic run(input logic [15:0] w, input bit legal);
      int k;
      instr_word = w;
      instr_valid = 1'b1;
      @(negedge clk);
      instr_valid = 1'b0;
      chk("busy", 8'h01, {7'h00, busy});
      k = 0;
      while (done !== 1'b1 && illegal !== 1'b1 && k < 12) begin
         @(negedge clk);
         k++;
      end
      if (k >= 12) begin
         n_mismatch++;
         report_and_stop();
      end
      chk("latency", legal ? 8'h04 : 8'h01, 8'(k));
      chk("done", {7'h00, legal}, {7'h00, done});
      chk("illegal", {7'h00, !legal}, {7'h00, illegal});
      @(negedge clk);
      chk("pulse", 8'h00, {6'h00, done, busy});
   endtask : run

   task automatic mem_chk(input logic [11:0] ad, input logic [7:0] exp);
      peek_addr = ad;
      @(negedge clk);
      chk("mem", exp, peek_data);
   endtask : mem_chk

   // worked example: result back to the byte, accumulator kept
   task automatic t_to_mem();
      setup(8'h02, 5'h01, 12'h010, 8'h03);
      run({sub_borrow_pkg::OPCODE, 1'b1, 1'b0, 8'h10}, 1'b1);
      chk("acc", 8'h02, acc);
      chk("flags", 8'h10, {3'h0, flags});
      mem_chk(12'h010, 8'hFF);
   endtask : t_to_mem

   // result to accumulator through the bank select register
   task automatic t_to_acc();
      bank_select_reg = 4'h3;
      setup(8'h05, 5'h01, 12'h3A5, 8'h02);
      run({sub_borrow_pkg::OPCODE, 1'b0, 1'b1, 8'hA5}, 1'b1);
      chk("acc", 8'h03, acc);
      chk("flags", 8'h03, {3'h0, flags});
      mem_chk(12'h3A5, 8'h02);
   endtask : t_to_acc

   // flag corner cases: borrow in, signed overflow both ways, zero
   task automatic t_flags();
      logic [7:0] tab_a[4] = '{8'h00, 8'h80, 8'h01, 8'h7F};
      logic [7:0] tab_m[4] = '{8'h00, 8'h01, 8'h01, 8'hFF};
      logic [7:0] tab_r[4] = '{8'hFF, 8'h7F, 8'h00, 8'h80};
      logic [4:0] tab_f[4] = '{5'h10, 5'h09, 5'h07, 5'h1A};
      for (int i = 0; i < 4; i++) begin
         setup(tab_a[i], (i == 0) ? 5'h1E : 5'h01, 12'h020, tab_m[i]);
         run({sub_borrow_pkg::OPCODE, 1'b0, 1'b0, 8'h20}, 1'b1);
         chk("acc", tab_r[i], acc);
         chk("flags", {3'h0, tab_f[i]}, {3'h0, flags});
      end
   endtask : t_flags

   // operand address selection across bank and indexed modes
   task automatic t_addr();
      logic tab_a[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      logic tab_x[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      logic [7:0] tab_f[5] = '{8'h90, 8'h5F, 8'h60, 8'hFF, 8'h20};
      logic [11:0] tab_e[5] = '{12'hF90, 12'h45F, 12'h060, 12'hFFF, 12'h720};
      index_base = 12'h400;
      bank_select_reg = 4'h7;
      for (int i = 0; i < 5; i++) begin
         ext_set_enable = tab_x[i];
         setup(8'h10, 5'h01, tab_e[i], 8'h04);
         run({sub_borrow_pkg::OPCODE, 1'b1, tab_a[i], tab_f[i]}, 1'b1);
         mem_chk(tab_e[i], 8'h0C);
         chk("flags", 8'h01, {3'h0, flags});
      end
      ext_set_enable = 1'b0;
   endtask : t_addr

   // wrong opcode: no done, nothing written
   task automatic t_illegal();
      setup(8'h33, 5'h01, 12'h011, 8'h01);
      run({6'h14, 1'b1, 1'b0, 8'h11}, 1'b0);
      chk("acc", 8'h33, acc);
      mem_chk(12'h011, 8'h01);
   endtask : t_illegal

   // main sequence
   initial begin
      n_mismatch = 0;
      n_tests = 0;
      rst = 1'b1;
      instr_valid = 1'b0;
      instr_word = 16'h0000;
      ext_set_enable = 1'b0;
      bank_select_reg = 4'h0;
      index_base = 12'h000;
      acc_load = 1'b0;
      acc_load_value = 8'h00;
      flags_load = 1'b0;
      flags_load_value = 5'h00;
      mem_load = 1'b0;
      mem_load_addr = 12'h000;
      mem_load_data = 8'h00;
      peek_addr = 12'h000;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      chk("acc", 8'h00, acc);
      chk("flags", 8'h00, {3'h0, flags});
      chk("busy", 8'h00, {7'h00, busy});
      t_to_mem();
      t_to_acc();
      t_flags();
      t_addr();
      t_illegal();
      report_and_stop();
   end
endmodule : subtract_with_borrow_exec_tb_top

//--- hdl/byte_mem.sv
`timescale 1ns/1ns
module byte_mem #(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 8
) (
   input wire logic clk,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [DATA_W-1:0] rd_data,
   input wire logic we,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // registered read, simple write
   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
      if (we) begin
         mem[wr_addr] <= wr_data;
      end
   end
endmodule : byte_mem

//--- hdl/sub_borrow_pkg.sv
// Operation
// RULE_01: result is accumulator minus byte minus borrow
// RULE_02: decode opcode 010101, then d, a, address
// RULE_03: address 0..255, d and a single bits
// RULE_04: d=0 writes accumulator, d=1 writes byte
// RULE_05: a=0 access bank, a=1 bank select
// RULE_06: a=0, extended set, f<=95: indexed offset
// RULE_07: update N, overflow, carry, digit carry, Z only
// RULE_08: one word, four phases: decode, read, compute, write
// RULE_09: carries mean no borrow; signed overflow; N, Z
package sub_borrow_pkg;
   // instruction word fields
   localparam logic [5:0] OPCODE = 6'h15;
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 10;
   localparam int DEST_BIT = 9;
   localparam int BANK_BIT = 8;
   localparam int ADDR_HI = 7;
   // addressing
   localparam logic [7:0] INDEX_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   // flag positions inside the flags output
   localparam int FLAG_C = 0;
   localparam int FLAG_DIGIT_CARRY = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OVERFLOW = 3;
   localparam int FLAG_N = 4;
   // reset values
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [4:0] FLAGS_RESET = 5'h00;
   // phase states, one-hot
   typedef enum logic [4:0] {
      PH_IDLE = 5'h01,
      PH_Q1 = 5'h02,
      PH_Q2 = 5'h04,
      PH_Q3 = 5'h08,
      PH_Q4 = 5'h10
   } phase_t;
endpackage : sub_borrow_pkg

//--- hdl/subtract_with_borrow_exec.sv
`timescale 1ns/1ns
module subtract_with_borrow_exec #(
   parameter int MEM_ADDR_W = 12
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic ext_set_enable,
   input wire logic [MEM_ADDR_W-9:0] bank_select_reg,
   input wire logic [MEM_ADDR_W-1:0] index_base,
   input wire logic acc_load,
   input wire logic [7:0] acc_load_value,
   input wire logic flags_load,
   input wire logic [4:0] flags_load_value,
   input wire logic mem_load,
   input wire logic [MEM_ADDR_W-1:0] mem_load_addr,
   input wire logic [7:0] mem_load_data,
   input wire logic [MEM_ADDR_W-1:0] peek_addr,
   output logic [7:0] peek_data,
   output logic [7:0] acc,
   output logic [4:0] flags,
   output logic busy,
   output logic done,
   output logic illegal
);
   localparam int BANK_W = MEM_ADDR_W - 8;

   // refuse memories without room for at least sixteen banks
   generate
      if (BANK_W < 4) begin : g_bad_width
         $error("MEM_ADDR_W must be at least 12");
      end
   endgenerate

   sub_borrow_pkg::phase_t state;
   sub_borrow_pkg::phase_t next_state;
   logic [15:0] instr;
   logic ext_hold;
   logic [BANK_W-1:0] bank_hold;
   logic [MEM_ADDR_W-1:0] base_hold;
   logic [MEM_ADDR_W-1:0] eff_addr;
   logic [7:0] result;
   logic [4:0] next_flags_calc;
   logic [4:0] flags_calc_hold;
   logic [7:0] mem_rd_data;

   // instruction field decode
   wire [5:0] opc_field = instr[sub_borrow_pkg::OPC_HI:sub_borrow_pkg::OPC_LO];
   wire opcode_ok = (opc_field == sub_borrow_pkg::OPCODE); // see RULE_02
   wire dest_mem = instr[sub_borrow_pkg::DEST_BIT]; // see RULE_03
   wire bank_mode = instr[sub_borrow_pkg::BANK_BIT];
   wire [7:0] f_addr = instr[sub_borrow_pkg::ADDR_HI:0]; // see RULE_03
   wire accept = instr_valid && (state == sub_borrow_pkg::PH_IDLE);

   // operand address selection
   wire use_indexed = !bank_mode && ext_hold && (f_addr <= sub_borrow_pkg::INDEX_LIMIT); // see RULE_06
   wire [MEM_ADDR_W-1:0] indexed_addr = base_hold + {{BANK_W{1'b0}}, f_addr}; // see RULE_06
   wire [3:0] access_bank = f_addr[7] ? sub_borrow_pkg::ACCESS_HIGH_BANK : sub_borrow_pkg::ACCESS_LOW_BANK;
   // high access half sign-extends into the top bank for any memory width
   wire [MEM_ADDR_W-1:0] access_addr = MEM_ADDR_W'(signed'({access_bank, f_addr})); // see RULE_05
   wire [MEM_ADDR_W-1:0] banked_addr = {bank_hold, f_addr}; // see RULE_05
   wire [MEM_ADDR_W-1:0] next_eff_addr = bank_mode ? banked_addr : (use_indexed ? indexed_addr : access_addr);

   // subtraction as acc + ~op + carry, carry high means no borrow
   wire carry_in = flags[sub_borrow_pkg::FLAG_C];
   wire [8:0] sum9 = {1'b0, acc} + {1'b0, ~mem_rd_data} + {8'h00, carry_in}; // see RULE_01
   wire [4:0] sum5 = {1'b0, acc[3:0]} + {1'b0, ~mem_rd_data[3:0]} + {4'h0, carry_in}; // see RULE_09
   wire [7:0] next_result = sum9[7:0];
   wire ovf = (acc[7] != mem_rd_data[7]) && (next_result[7] != acc[7]); // see RULE_09

   // flag vector for the result
   always_comb begin
      next_flags_calc = 5'h00;
      next_flags_calc[sub_borrow_pkg::FLAG_C] = sum9[8]; // see RULE_09
      next_flags_calc[sub_borrow_pkg::FLAG_DIGIT_CARRY] = sum5[4]; // see RULE_09
      next_flags_calc[sub_borrow_pkg::FLAG_Z] = (next_result == 8'h00);
      next_flags_calc[sub_borrow_pkg::FLAG_OVERFLOW] = ovf;
      next_flags_calc[sub_borrow_pkg::FLAG_N] = next_result[7];
   end

   // four phase sequencer
   always_comb begin
      case (state)
         sub_borrow_pkg::PH_IDLE: next_state = instr_valid ? sub_borrow_pkg::PH_Q1 : sub_borrow_pkg::PH_IDLE;
         sub_borrow_pkg::PH_Q1: next_state = opcode_ok ? sub_borrow_pkg::PH_Q2 : sub_borrow_pkg::PH_IDLE;
         sub_borrow_pkg::PH_Q2: next_state = sub_borrow_pkg::PH_Q3;
         sub_borrow_pkg::PH_Q3: next_state = sub_borrow_pkg::PH_Q4;
         sub_borrow_pkg::PH_Q4: next_state = sub_borrow_pkg::PH_IDLE;
         default: next_state = sub_borrow_pkg::PH_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= sub_borrow_pkg::PH_IDLE;
      end else begin
         state <= next_state; // see RULE_08
      end
   end

   // latch the instruction and its context on accept
   always_ff @(posedge clk) begin
      if (rst) begin
         instr <= 16'h0000;
         ext_hold <= 1'b0;
         bank_hold <= '0;
         base_hold <= '0;
      end else if (accept) begin
         instr <= instr_word;
         ext_hold <= ext_set_enable;
         bank_hold <= bank_select_reg;
         base_hold <= index_base;
      end
   end

   // address in the decode phase, result in the compute phase
   always_ff @(posedge clk) begin
      if (rst) begin
         eff_addr <= '0;
         result <= 8'h00;
         flags_calc_hold <= 5'h00;
      end else begin
         if (state == sub_borrow_pkg::PH_Q1) begin
            eff_addr <= next_eff_addr;
         end
         if (state == sub_borrow_pkg::PH_Q3) begin
            result <= next_result; // see RULE_01
            flags_calc_hold <= next_flags_calc;
         end
      end
   end

   // accumulator and flags: written back in the write phase
   always_ff @(posedge clk) begin
      if (rst) begin
         acc <= sub_borrow_pkg::ACC_RESET;
         flags <= sub_borrow_pkg::FLAGS_RESET;
      end else if (state == sub_borrow_pkg::PH_Q4) begin
         if (!dest_mem) begin
            acc <= result; // see RULE_04
         end
         flags <= flags_calc_hold; // see RULE_07
      end else if (state == sub_borrow_pkg::PH_IDLE) begin
         if (acc_load) begin
            acc <= acc_load_value;
         end
         if (flags_load) begin
            flags <= flags_load_value;
         end
      end
   end

   // status outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         busy <= 1'b0;
         done <= 1'b0;
         illegal <= 1'b0;
      end else begin
         busy <= (next_state != sub_borrow_pkg::PH_IDLE);
         done <= (state == sub_borrow_pkg::PH_Q4);
         illegal <= (state == sub_borrow_pkg::PH_Q1) && !opcode_ok; // see RULE_02
      end
   end

   // memory port selection: core owns reads in Q2, writes in Q4
   wire core_rd = (state == sub_borrow_pkg::PH_Q2);
   wire core_wr = (state == sub_borrow_pkg::PH_Q4) && dest_mem; // see RULE_04
   wire [MEM_ADDR_W-1:0] mem_rd_addr = core_rd ? eff_addr : peek_addr;
   wire mem_we = core_wr || (mem_load && (state == sub_borrow_pkg::PH_IDLE));
   wire [MEM_ADDR_W-1:0] mem_wr_addr = core_wr ? eff_addr : mem_load_addr;
   wire [7:0] mem_wr_data = core_wr ? result : mem_load_data;

   byte_mem #(.ADDR_W(MEM_ADDR_W), .DATA_W(8)) u_mem (
      .clk(clk),
      .rd_addr(mem_rd_addr),
      .rd_data(mem_rd_data),
      .we(mem_we),
      .wr_addr(mem_wr_addr),
      .wr_data(mem_wr_data)
   );

   assign peek_data = mem_rd_data;

   // checks
   sequence s_phases;
      state == sub_borrow_pkg::PH_Q2 ##1 state == sub_borrow_pkg::PH_Q3 ##1 state == sub_borrow_pkg::PH_Q4
         ##1 done;
   endsequence

   sequence s_decoded;
      state == sub_borrow_pkg::PH_Q1 && opcode_ok;
   endsequence

   property p_phases;
      @(posedge clk) disable iff (rst) s_decoded |=> s_phases;
   endproperty
   a_phases: assert property (p_phases) else $error("phase order broken"); // see RULE_08

   property p_reject;
      @(posedge clk) disable iff (rst) (state == sub_borrow_pkg::PH_Q1 && !opcode_ok)
         |=> (state == sub_borrow_pkg::PH_IDLE) && illegal && !done;
   endproperty
   a_reject: assert property (p_reject) else $error("foreign opcode not rejected"); // see RULE_02

   property p_diff;
      @(posedge clk) disable iff (rst) (state == sub_borrow_pkg::PH_Q3)
         |=> result == 8'($past(acc) - $past(mem_rd_data) - {7'h00, !$past(carry_in)});
   endproperty
   a_diff: assert property (p_diff) else $error("difference wrong"); // see RULE_01

   property p_dest_acc;
      @(posedge clk) disable iff (rst) (state == sub_borrow_pkg::PH_Q4 && !dest_mem) |=> acc == $past(result);
   endproperty
   a_dest_acc: assert property (p_dest_acc) else $error("accumulator not written"); // see RULE_04

   property p_dest_mem;
      @(posedge clk) disable iff (rst) (state == sub_borrow_pkg::PH_Q4 && dest_mem)
         |-> mem_we && mem_wr_addr == eff_addr && mem_wr_data == result ##1 $stable(acc);
   endproperty
   a_dest_mem: assert property (p_dest_mem) else $error("byte not written back"); // see RULE_04

   property p_banked;
      @(posedge clk) disable iff (rst) (state == sub_borrow_pkg::PH_Q1 && bank_mode)
         |=> eff_addr == {bank_hold, f_addr};
   endproperty
   a_banked: assert property (p_banked) else $error("bank select address wrong"); // see RULE_05

   property p_indexed;
      @(posedge clk) disable iff (rst) (state == sub_borrow_pkg::PH_Q1 && !bank_mode && ext_hold
         && f_addr <= sub_borrow_pkg::INDEX_LIMIT) |=> eff_addr == base_hold + {{BANK_W{1'b0}}, f_addr};
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed address wrong"); // see RULE_06

   property p_flags;
      @(posedge clk) disable iff (rst) (state == sub_borrow_pkg::PH_Q4)
         |=> flags[sub_borrow_pkg::FLAG_N] == $past(result[7])
         && flags[sub_borrow_pkg::FLAG_Z] == ($past(result) == 8'h00);
   endproperty
   a_flags: assert property (p_flags) else $error("N or Z flag wrong"); // see RULE_07

   property p_carry;
      @(posedge clk) disable iff (rst) (state == sub_borrow_pkg::PH_Q3) ##1 1'b1
         |=> flags[sub_borrow_pkg::FLAG_C] == $past(sum9[8], 2)
         && flags[sub_borrow_pkg::FLAG_DIGIT_CARRY] == $past(sum5[4], 2);
   endproperty
   a_carry: assert property (p_carry) else $error("carry or digit carry wrong"); // see RULE_09
endmodule : subtract_with_borrow_exec
